// *** rtl/sol_strap_latch.sv ***
// Strap option latch: samples strap pins during hardware reset and holds the modes.
//
// Function
// - Sample strap pins during reset, select modes.
// - Five address straps form management address.
// - Every address zero through thirty-one valid.
// - Strapped address zero enters isolate state.
// - Software writing zero never causes isolation.
// - Advertisement strap loads control, advertisement defaults.
// - Strap 0 half duplex; 1 half/full.
// - Unfitted advertisement strap reads as 1.
// - Interface strap 0 MII, 1 RMII.
// - LED strap picks mode; register overrides.
// - Crossover enabled unless strap pulled low.
// - Reset pin low one microsecond reinitialises all.
`timescale 1ns/1ns
module sol_strap_latch
    import sol_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // Hardware reset pin
    input  wire logic               hw_reset_n_pin,
    // Strap pins
    input  wire logic               mgmt_addr_bit0_strap,
    input  wire logic               mgmt_addr_bit1_strap,
    input  wire logic               mgmt_addr_bit2_strap,
    input  wire logic               mgmt_addr_bit3_strap,
    input  wire logic               mgmt_addr_bit4_strap,
    input  wire logic               advert_select_strap,
    input  wire logic               mac_if_select_strap,
    input  wire logic               led_mode_strap,
    input  wire logic               crossover_enable_strap,
    // Software writes to the control fields
    input  wire logic               addr_wr,
    input  wire logic [ADDR_W-1:0]  addr_wdata,
    input  wire logic               led_mode_wr,
    input  wire logic [LED_W-1:0]   led_mode_wdata,
    // Latched modes
    output logic                    hw_reset_active,
    output logic [ADDR_W-1:0]       mgmt_addr,
    output logic                    isolate,
    output logic                    advert_select_value,
    output logic [ADV_W-1:0]        advert_abilities,
    output logic                    rmii_mode,
    output logic [LED_W-1:0]        led_mode,
    output logic                    crossover_enable
);

    typedef struct packed {
        sol_state_t             st;
        logic [LOW_CNT_W-1:0]   low_cnt;
        logic                   in_reset;
        logic [ADDR_W-1:0]      addr;
        logic                   iso;
        logic                   adv_sel;
        logic [ADV_W-1:0]       adv;
        logic                   rmii;
        logic [LED_W-1:0]       led;
        logic                   xover;
    } sol_regs_t;

    // Pull defaults stand in for pins while the bank is in reset.
    localparam sol_regs_t REGS_RESET = '{
        st:       SOL_SAMPLE,
        low_cnt:  '0,
        in_reset: 1'b1,
        addr:     ADDR_RESET,
        iso:      1'b0,
        adv_sel:  1'b1,
        adv:      ADV_HALF_FULL,
        rmii:     1'b0,
        led:      LED_MODE_1,
        xover:    1'b1
    };

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins;
    logic [ADDR_W-1:0] s_addr;
    logic             s_rst_n;
    sol_regs_t        cur;
    sol_regs_t        next_regs;

    assign pins_raw = {hw_reset_n_pin, crossover_enable_strap, led_mode_strap, mac_if_select_strap,
                       advert_select_strap, mgmt_addr_bit4_strap, mgmt_addr_bit3_strap,
                       mgmt_addr_bit2_strap, mgmt_addr_bit1_strap, mgmt_addr_bit0_strap};

    sol_sync #(
        .W    (PIN_W),
        .INIT (PIN_DEFAULTS)
    ) sol_sync_i (
        .clock (clock),
        .rst   (rst),
        .d     (pins_raw),
        .q     (pins)
    );

    assign s_addr  = pins[POS_ADDR +: ADDR_W];
    assign s_rst_n = pins[POS_RST_N];

    always_comb begin
        next_regs = cur;
        if (s_rst_n) begin
            next_regs.low_cnt = '0;
        end else if (cur.low_cnt != RESET_MIN_CYCLES) begin
            next_regs.low_cnt = cur.low_cnt + 1'b1;
        end
        case (cur.st)
            SOL_RUN: begin
                if (!s_rst_n && next_regs.low_cnt == RESET_MIN_CYCLES) begin
                    next_regs.st = SOL_SAMPLE;
                end
                if (addr_wr) begin
                    next_regs.addr = addr_wdata;
                end
                if (led_mode_wr) begin
                    next_regs.led = led_mode_wdata;
                end
            end
            SOL_SAMPLE: begin
                next_regs.addr    = s_addr;
                next_regs.iso     = (s_addr == ADDR_ISOLATE);
                // Pull-up default reaches here as one.
                next_regs.adv_sel = pins[POS_ADV];
                next_regs.adv     = pins[POS_ADV] ? ADV_HALF_FULL : ADV_HALF_ONLY;
                next_regs.rmii    = pins[POS_IFSEL];
                next_regs.led     = pins[POS_LED] ? LED_MODE_1 : LED_MODE_2;
                next_regs.xover   = pins[POS_XOVER];
                if (s_rst_n) begin
                    next_regs.st = SOL_RUN;
                end
            end
            default: begin
                next_regs.st = SOL_SAMPLE;
            end
        endcase
        next_regs.in_reset = (next_regs.st == SOL_SAMPLE);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= REGS_RESET;
        end else begin
            cur <= next_regs;
        end
    end

    assign hw_reset_active     = cur.in_reset;
    assign mgmt_addr           = cur.addr;
    assign isolate             = cur.iso;
    assign advert_select_value = cur.adv_sel;
    assign advert_abilities    = cur.adv;
    assign rmii_mode           = cur.rmii;
    assign led_mode            = cur.led;
    assign crossover_enable    = cur.xover;

    a_addr_capture: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> mgmt_addr == $past(s_addr))
        else $error("address not captured from straps");

    a_isolate_strap: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> isolate == ($past(s_addr) == ADDR_ISOLATE))
        else $error("isolate does not follow strapped zero");

    a_isolate_write: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN && addr_wr |=> $stable(isolate) && mgmt_addr == $past(addr_wdata))
        else $error("address write disturbed isolate or was lost");

    a_advert_map: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> advert_abilities == ($past(pins[POS_ADV]) ? ADV_HALF_FULL : ADV_HALF_ONLY))
        else $error("advertised abilities wrong for strap");

    a_ifsel_xover: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> rmii_mode == $past(pins[POS_IFSEL]) && crossover_enable == $past(pins[POS_XOVER]))
        else $error("interface or crossover strap not applied");

    a_led_write: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN && led_mode_wr |=> led_mode == $past(led_mode_wdata))
        else $error("LED mode write not applied");

    a_hold_run: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN |=> $stable(rmii_mode) && $stable(crossover_enable) && $stable(advert_abilities))
        else $error("latched straps changed outside reset");

    a_reset_entry: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN && !s_rst_n && cur.low_cnt == RESET_MIN_CYCLES - 8'h01 |=> hw_reset_active)
        else $error("qualified reset low not taken");

    a_short_low: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN && cur.low_cnt < RESET_MIN_CYCLES - 8'h01 |=> !hw_reset_active)
        else $error("reset taken before least low time");

    a_advert_latch: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> advert_select_value == $past(pins[POS_ADV]))
        else $error("advertisement strap not latched");

    a_led_strap: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE |=> led_mode == ($past(pins[POS_LED]) ? LED_MODE_1 : LED_MODE_2))
        else $error("LED mode does not follow strap");

    a_addr_hold: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_RUN && !addr_wr |=> $stable(mgmt_addr))
        else $error("address changed without a write");

    a_release_exit: assert property (@(posedge clock) disable iff (rst)
        cur.st == SOL_SAMPLE && s_rst_n |=> !hw_reset_active)
        else $error("sampling not ended at pin release");

endmodule : sol_strap_latch

// *** rtl/sol_pkg.sv ***
// Constants shared by the strap option latch.
package sol_pkg;

    // Clock rate and the least low time of the hardware reset pin.
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          RESET_MIN_NS      = 1000;
    localparam int          RESET_MIN_INT     = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LOW_CNT_W         = 8;
    localparam logic [7:0]  RESET_MIN_CYCLES  = RESET_MIN_INT[7:0];

    // Widths of the strap fields.
    localparam int          ADDR_W            = 5;
    localparam int          ADV_W             = 4;
    localparam int          LED_W             = 2;

    // Bit positions in the gathered strap vector.
    localparam int          POS_ADDR          = 0;
    localparam int          POS_ADV           = 5;
    localparam int          POS_IFSEL         = 6;
    localparam int          POS_LED           = 7;
    localparam int          POS_XOVER         = 8;
    localparam int          POS_RST_N         = 9;
    localparam int          PIN_W             = 10;

    // Levels set by the internal pulls when no resistor is fitted.
    localparam logic [9:0]  PIN_DEFAULTS      = 10'h3BF;

    // Advertised abilities, ordered {100 full, 100 half, 10 full, 10 half}.
    localparam logic [3:0]  ADV_HALF_ONLY     = 4'h5;
    localparam logic [3:0]  ADV_HALF_FULL     = 4'hF;

    // LED mode codes.
    localparam logic [1:0]  LED_MODE_1        = 2'h1;
    localparam logic [1:0]  LED_MODE_2        = 2'h2;

    // Reset value of the latched address, and the strapped address that enters isolate.
    localparam logic [4:0]  ADDR_RESET        = 5'h1F;
    localparam logic [4:0]  ADDR_ISOLATE      = 5'h00;

    typedef enum logic {
        SOL_RUN,
        SOL_SAMPLE
    } sol_state_t;

endpackage : sol_pkg

// *** rtl/sol_sync.sv ***
// Two-stage synchroniser bank for the strap and reset pins.
`timescale 1ns/1ns
module sol_sync #(
    parameter int               W    = 1,
    parameter logic [W-1:0]     INIT = '0
) (
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rst,
    // Pin levels in and synchronised levels out
    input  wire logic [W-1:0]   d,
    output logic [W-1:0]        q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sol_sync_regs_t;

    sol_sync_regs_t cur;
    sol_sync_regs_t next_regs;

    // Only the second stage leaves the bank, so a metastable first stage never reaches logic.
    always_comb begin
        next_regs.meta = d;
        next_regs.q    = cur.meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cur <= '{meta: INIT, q: INIT};
        end else begin
            cur <= next_regs;
        end
    end

    assign q = cur.q;

endmodule : sol_sync

// *** test/sol_board_model.sv ***
// Board side of the strap pins: pull resistors, internal pulls and the reset source.
`timescale 1ns/1ns
module sol_board_model
    import sol_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Board setup chosen by the bench
    input  wire logic [8:0]  fit,
    input  wire logic [8:0]  lvl,
    input  wire logic        hold_reset,
    input  wire logic        func_on,
    // Pin levels seen by the device
    output logic [8:0]       straps,
    output logic             hw_reset_n_pin
);
    logic [8:0]  resolved;

    // fitted resistor or the internal pull
    assign resolved = (fit & lvl) | (~fit & PIN_DEFAULTS[8:0]);
    // pin low only while the source holds reset
    assign hw_reset_n_pin = ~hold_reset;

    initial straps = PIN_DEFAULTS[8:0];
    // While func_on is set and reset is not held, the shared pins carry traffic, so they toggle every cycle.
    always @(posedge clock) begin
        straps <= (func_on && !hold_reset) ? ~straps : resolved;
    end
endmodule : sol_board_model

// *** test/sol_strap_latch_tb.sv ***
// Self-checking bench for the strap option latch.
`timescale 1ns/1ns
module sol_strap_latch_tb;
    import sol_pkg::*;
    logic        clock, rst, hold_reset, func_on, addr_wr, led_mode_wr;
    logic [8:0]  fit, lvl, straps;
    logic [4:0]  addr_wdata, mgmt_addr;
    logic [1:0]  led_mode_wdata, led_mode;
    logic [3:0]  advert_abilities;
    logic        hw_reset_n_pin, hw_reset_active, isolate, advert_select_value, rmii_mode, crossover_enable;
    int          errors, n_checks, cycles;

    sol_board_model sol_board_model_i (.clock(clock), .fit(fit), .lvl(lvl), .hold_reset(hold_reset),
        .func_on(func_on), .straps(straps), .hw_reset_n_pin(hw_reset_n_pin));
    sol_strap_latch sol_strap_latch_i (.clock(clock), .rst(rst), .hw_reset_n_pin(hw_reset_n_pin),
        .mgmt_addr_bit0_strap(straps[0]), .mgmt_addr_bit1_strap(straps[1]), .mgmt_addr_bit2_strap(straps[2]),
        .mgmt_addr_bit3_strap(straps[3]), .mgmt_addr_bit4_strap(straps[4]), .advert_select_strap(straps[5]),
        .mac_if_select_strap(straps[6]), .led_mode_strap(straps[7]), .crossover_enable_strap(straps[8]),
        .addr_wr(addr_wr), .addr_wdata(addr_wdata), .led_mode_wr(led_mode_wr), .led_mode_wdata(led_mode_wdata),
        .hw_reset_active(hw_reset_active), .mgmt_addr(mgmt_addr), .isolate(isolate),
        .advert_select_value(advert_select_value), .advert_abilities(advert_abilities), .rmii_mode(rmii_mode),
        .led_mode(led_mode), .crossover_enable(crossover_enable));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out();
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // The run needs about 4150 cycles; the ceiling leaves ample margin.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic expect_modes(input logic [4:0] a, input logic adv, ifs, led, xo);
        check(hw_reset_active, 1'b0);
        check(mgmt_addr, a);
        check(isolate, a == 5'h00);
        check(advert_select_value, adv);
        check(advert_abilities, adv ? ADV_HALF_FULL : ADV_HALF_ONLY);
        check(rmii_mode, ifs);
        check(led_mode, led ? LED_MODE_1 : LED_MODE_2);
        check(crossover_enable, xo);
    endtask : expect_modes

    task automatic strap_run(input logic fitted, input logic [4:0] a, input logic adv, ifs, led, xo);
        int k;
        fit = fitted ? 9'h1FF : 9'h000;
        lvl = {xo, led, ifs, adv, a};
        hold_reset = 1'b1;
        cyc(95);
        check(hw_reset_active, 1'b0);
        cyc(15);
        check(hw_reset_active, 1'b1);
        hold_reset = 1'b0;
        k = 0;
        while (hw_reset_active !== 1'b0 && k < 20) begin
            cyc(1);
            k++;
        end
        cyc(1);
        expect_modes(a, adv, ifs, led, xo);
    endtask : strap_run

    task automatic t_short_pulse();
        lvl = 9'h000;
        hold_reset = 1'b1;
        repeat (50) begin
            cyc(1);
            check(hw_reset_active, 1'b0);
        end
        hold_reset = 1'b0;
        cyc(10);
        expect_modes(5'h0A, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask : t_short_pulse

    task automatic t_writes();
        addr_wr = 1'b1;
        addr_wdata = 5'h00;
        cyc(1);
        check(mgmt_addr, 5'h00);
        check(isolate, 1'b0);
        addr_wdata = 5'h12;
        cyc(1);
        check(mgmt_addr, 5'h12);
        addr_wr = 1'b0;
        led_mode_wr = 1'b1;
        led_mode_wdata = 2'h3;
        cyc(1);
        led_mode_wr = 1'b0;
        check(led_mode, 2'h3);
    endtask : t_writes

    task automatic t_hold();
        func_on = 1'b1;
        cyc(60);
        func_on = 1'b0;
        cyc(5);
        expect_modes(5'h0A, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask : t_hold

    initial begin
        rst = 1'b1;
        hold_reset = 1'b0;
        func_on = 1'b0;
        addr_wr = 1'b0;
        led_mode_wr = 1'b0;
        addr_wdata = 5'h00;
        led_mode_wdata = 2'h0;
        fit = 9'h000;
        lvl = 9'h000;
        cyc(20);
        rst = 1'b0;
        cyc(8);
        expect_modes(5'h1F, 1'b1, 1'b0, 1'b1, 1'b1);
        strap_run(1'b0, 5'h1F, 1'b1, 1'b0, 1'b1, 1'b1);
        for (int a = 0; a < 32; a++) begin
            strap_run(1'b1, a[4:0], a[0], a[1], a[2], a[3]);
        end
        strap_run(1'b1, 5'h0A, 1'b0, 1'b1, 1'b0, 1'b1);
        t_hold();
        t_short_pulse();
        t_writes();
        strap_run(1'b1, 5'h07, 1'b1, 1'b0, 1'b1, 1'b0);
        close_out();
    end
endmodule : sol_strap_latch_tb
